// File: verilog/dram_regs.svh
// Contract
// (RQ1) data store is 4096 bytes, static
// (RQ2) address generator is three loadable counters
// (RQ3) write 6009 loads low address byte
// (RQ4) write RAM_START_ADDR_HIGH_PAGE loads top bits and page
// (RQ5) counters load only on processor write
// (RQ6) granted transfer moves fifo words to ram
// (RQ7) count pulse after every transfer byte written; code gives none for a byte written after request drops
// (RQ8) stop on overflow or dropped transfer request
// (RQ9) processor granted only if transfer idle
// (RQ10) processor holds request through whole access
// (RQ11) transfer granted only if processor idle
// (RQ12) overflow blocks new transfer grants
// (RQ13) overflow from top counter carry, latched
// (RQ14) 6005 bit four zero disables; read status
// (RQ15) address mux: cpu bus when cpu granted
// (RQ16) top two address bits decode page selects
// (RQ17) strobe mux enabled only while granted
// (RQ18) fifo word written low byte first
// (RQ19) simultaneous requests: processor wins
// (RQ20) grant released cycle after request drops
`ifndef DRAM_REGS_SVH
`define DRAM_REGS_SVH
`define DRAM_AW 12
`define DRAM_DEPTH 4096
`define DRAM_OFS_OVF 16'h6005
`define DRAM_OFS_ALO 16'h6009
`define DRAM_OFS_AHI 16'h600A
`define DRAM_OVF_EN_BIT 4
`define DRAM_PAGE_MSB 11
`define DRAM_PAGE_LSB 10
`define DRAM_HI_ADDR_MSB 1
`define DRAM_HI_PAGE_MSB 3
`define DRAM_HI_PAGE_LSB 2
`define DRAM_FIFO_DEPTH 8
`define DRAM_WORD_W 16
`endif

// File: verilog/dram_pkg.sv
`default_nettype none
package dram_pkg;
  typedef enum logic [1:0] {GNT_IDLE, GNT_CPU, GNT_XFER} gnt_t;
  typedef enum logic [1:0] {XS_IDLE, XS_LOW, XS_HIGH} xs_t;
endpackage
`default_nettype wire

// File: verilog/dram_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dram_if;
  logic xfer_ram_request;
  logic xfer_ram_grant;
  logic [15:0] word_data;
  logic word_valid;
  logic word_ready;
  logic ram_addr_count_pulse;
  logic overflow;
  modport dev (input xfer_ram_request, word_data, word_valid,
    output xfer_ram_grant, word_ready, ram_addr_count_pulse, overflow);
  modport xfer (output xfer_ram_request, word_data, word_valid,
    input xfer_ram_grant, word_ready, ram_addr_count_pulse, overflow);
endinterface
`default_nettype wire

// File: verilog/dram_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module dram_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // fill side
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  // drain side
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;
  fifo_st_t st_r, st_nxt;
  logic push, pop;
  // ---------------------------------------
  // pointer and storage update
  // ---------------------------------------
  always_comb begin
    st_nxt = st_r;
    push = i_valid && (st_r.cnt != (AW+1)'(DEPTH));
    pop = i_ready && (st_r.cnt != '0);
    if (push) begin
      st_nxt.mem[st_r.wp] = i_data;
      st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign o_ready = (st_r.cnt != (AW+1)'(DEPTH));
  assign o_valid = (st_r.cnt != '0);
  assign o_data = st_r.mem[st_r.rp];
endmodule
`default_nettype wire

// File: verilog/dram_xfer_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "dram_regs.svh"
module dram_xfer_end (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // user side
  input wire logic I_START,
  input wire logic [`DRAM_WORD_W-1:0] I_WORD,
  input wire logic I_WORD_VALID,
  output logic O_WORD_READY,
  output logic O_BUSY,
  // link
  dram_if.xfer lnk
);
  typedef struct packed {
    logic req;
    logic busy;
  } xe_st_t;
  xe_st_t st_r, st_nxt;
  // ---------------------------------------
  // request holds until overflow or user stops
  // ---------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (I_START && !st_r.busy) begin
      st_nxt.req = 1'b1;
      st_nxt.busy = 1'b1;
    end else if (st_r.busy && (lnk.overflow || !I_WORD_VALID && !I_START)) begin
      st_nxt.req = 1'b0; // RQ8
      st_nxt.busy = 1'b0;
    end
  end
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign lnk.xfer_ram_request = st_r.req;
  assign lnk.word_data = I_WORD;
  assign lnk.word_valid = I_WORD_VALID && st_r.req;
  assign O_WORD_READY = lnk.word_ready && st_r.req;
  assign O_BUSY = st_r.busy;
endmodule
`default_nettype wire

// File: verilog/dram_dev_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "dram_regs.svh"
module dram_dev_end #(
  parameter int FIFO_DEPTH = `DRAM_FIFO_DEPTH
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // processor side
  input wire logic [15:0] I_CPU_ADDRESS_BUS,
  input wire logic [7:0] I_CPU_DATA,
  input wire logic I_CPU_WRITE_STROBE,
  input wire logic I_CPU_READ_STROBE,
  input wire logic I_CPU_RAM_REQUEST,
  output logic [7:0] O_CPU_RDATA,
  output logic O_CPU_RAM_GRANT,
  // ram observation
  output logic [3:0] O_PAGE_SELECT,
  output logic [`DRAM_AW-1:0] O_RAM_ADDR,
  // link
  dram_if.dev lnk
);
  typedef struct packed {
    dram_pkg::gnt_t gnt;
    dram_pkg::xs_t xs;
    logic [`DRAM_AW-1:0] gen;
    logic [1:0] page;
    logic ovf_en;
    logic ovf;
    logic cnt_pulse;
    logic [7:0] rdata;
    logic [3:0] psel;
    logic [`DRAM_AW-1:0] raddr;
    logic cgnt;
    logic xgnt;
  } dev_st_t;
  dev_st_t st_r, st_nxt;
  logic [`DRAM_DEPTH-1:0][7:0] mem_r;
  logic [`DRAM_AW-1:0] ram_a;
  logic [7:0] ram_wd;
  logic ram_we;
  logic f_valid, f_pop;
  logic [`DRAM_WORD_W-1:0] f_data;
  logic cpu_wr;
  logic [`DRAM_AW:0] gen_inc;

  function automatic logic [3:0] page_dec(input logic [1:0] p);
    page_dec = 4'h1 << p; // RQ16
  endfunction

  function automatic logic reg_hit(input logic [15:0] a);
    reg_hit = (a == `DRAM_OFS_OVF) || (a == `DRAM_OFS_ALO) || (a == `DRAM_OFS_AHI);
  endfunction

  // ---------------------------------------
  // word buffer between link and ram
  // ---------------------------------------
  dram_fifo #(.WIDTH(`DRAM_WORD_W), .DEPTH(FIFO_DEPTH)) i_dram_fifo (
    .I_CLK(I_CLK),
    .I_SRST(I_SRST),
    .i_data(lnk.word_data),
    .i_valid(lnk.word_valid),
    .o_ready(lnk.word_ready),
    .o_data(f_data),
    .o_valid(f_valid),
    .i_ready(f_pop)
  );

  // ---------------------------------------
  // ram datapath
  // ---------------------------------------
  always_comb begin
    cpu_wr = I_CPU_WRITE_STROBE;
    ram_a = (st_r.gnt == dram_pkg::GNT_CPU) ? I_CPU_ADDRESS_BUS[`DRAM_AW-1:0] : st_r.gen; // RQ15
    ram_we = 1'b0;
    ram_wd = I_CPU_DATA;
    f_pop = 1'b0;
    if (st_r.gnt == dram_pkg::GNT_CPU) begin
      ram_we = cpu_wr && !reg_hit(I_CPU_ADDRESS_BUS); // RQ17
    end else if (st_r.gnt == dram_pkg::GNT_XFER && !st_r.ovf) begin
      if (st_r.xs == dram_pkg::XS_LOW && f_valid) begin
        ram_we = 1'b1; // RQ6
        ram_wd = f_data[7:0]; // RQ18
      end else if (st_r.xs == dram_pkg::XS_HIGH) begin
        ram_we = 1'b1;
        ram_wd = f_data[15:8]; // RQ18
        f_pop = 1'b1;
      end
    end
    gen_inc = {1'b0, st_r.gen} + 13'(1);
  end

  always_ff @(posedge I_CLK) begin
    if (ram_we) begin
      mem_r[ram_a] <= ram_wd; // RQ1
    end
  end

  // ---------------------------------------
  // arbiter, generator, overflow, registers
  // ---------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.cnt_pulse = 1'b0;

    // ---------------------------------------
    // arbiter and address generator
    // ---------------------------------------
    case (st_r.gnt)
      dram_pkg::GNT_IDLE: begin
        if (I_CPU_RAM_REQUEST) begin
          st_nxt.gnt = dram_pkg::GNT_CPU; // RQ9 RQ19
        end else if (lnk.xfer_ram_request && !st_r.ovf) begin
          st_nxt.gnt = dram_pkg::GNT_XFER; // RQ11 RQ12
          st_nxt.xs = dram_pkg::XS_LOW;
        end
      end
      dram_pkg::GNT_CPU: begin
        if (!I_CPU_RAM_REQUEST) begin
          st_nxt.gnt = dram_pkg::GNT_IDLE; // RQ10 RQ20
        end
      end
      dram_pkg::GNT_XFER: begin
        if (!lnk.xfer_ram_request || st_r.ovf) begin
          st_nxt.gnt = dram_pkg::GNT_IDLE; // RQ8 RQ20
          st_nxt.xs = dram_pkg::XS_IDLE;
        end else if (ram_we) begin
          st_nxt.xs = (st_r.xs == dram_pkg::XS_LOW) ? dram_pkg::XS_HIGH : dram_pkg::XS_LOW;
          st_nxt.gen = gen_inc[`DRAM_AW-1:0];
          st_nxt.cnt_pulse = 1'b1; // RQ7
          if (gen_inc[`DRAM_AW] && st_r.ovf_en) begin
            st_nxt.ovf = 1'b1; // RQ13
          end
        end
      end
      default: begin
        st_nxt.gnt = dram_pkg::GNT_IDLE;
      end
    endcase

    // ---------------------------------------
    // register writes
    // ---------------------------------------
    if (cpu_wr) begin // RQ5
      case (I_CPU_ADDRESS_BUS)
        `DRAM_OFS_ALO: begin
          st_nxt.gen[7:0] = I_CPU_DATA; // RQ2 RQ3
        end
        `DRAM_OFS_AHI: begin
          st_nxt.gen[`DRAM_AW-1:8] = {I_CPU_DATA[`DRAM_HI_ADDR_MSB:0], 2'b00}; // RQ4
          st_nxt.page = I_CPU_DATA[`DRAM_HI_PAGE_MSB:`DRAM_HI_PAGE_LSB];
        end
        `DRAM_OFS_OVF: begin
          st_nxt.ovf_en = I_CPU_DATA[`DRAM_OVF_EN_BIT]; // RQ14
          if (!I_CPU_DATA[`DRAM_OVF_EN_BIT]) begin
            st_nxt.ovf = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // ---------------------------------------
    // read data
    // ---------------------------------------
    st_nxt.rdata = 8'h00;
    if (I_CPU_READ_STROBE && I_CPU_ADDRESS_BUS == `DRAM_OFS_OVF) begin
      st_nxt.rdata = {3'b000, st_r.ovf_en, 3'b000, st_r.ovf}; // RQ14
    end else if (I_CPU_READ_STROBE && st_r.gnt == dram_pkg::GNT_CPU && !reg_hit(I_CPU_ADDRESS_BUS)) begin
      st_nxt.rdata = mem_r[ram_a];
    end

    // ---------------------------------------
    // page select, address and grant outputs
    // ---------------------------------------
    st_nxt.psel = (st_nxt.gnt != dram_pkg::GNT_IDLE) ? page_dec(ram_a[`DRAM_PAGE_MSB:`DRAM_PAGE_LSB]) : 4'h0; // RQ17
    st_nxt.raddr = ram_a;
    st_nxt.cgnt = (st_nxt.gnt == dram_pkg::GNT_CPU);
    st_nxt.xgnt = (st_nxt.gnt == dram_pkg::GNT_XFER);
  end

  // ---------------------------------------
  // state register
  // ---------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      st_r <= '0;
      st_r.gnt <= dram_pkg::GNT_IDLE;
      st_r.xs <= dram_pkg::XS_IDLE;
      st_r.ovf_en <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------
  // outputs
  // ---------------------------------------
  assign O_CPU_RDATA = st_r.rdata;
  assign O_CPU_RAM_GRANT = st_r.cgnt;
  assign O_PAGE_SELECT = st_r.psel;
  assign O_RAM_ADDR = st_r.raddr;
  assign lnk.xfer_ram_grant = st_r.xgnt;
  assign lnk.ram_addr_count_pulse = st_r.cnt_pulse;
  assign lnk.overflow = st_r.ovf;
endmodule
`default_nettype wire

// File: verif/dram_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dram_sva (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // link
  input wire logic xfer_ram_request,
  input wire logic xfer_ram_grant,
  input wire logic [15:0] word_data,
  input wire logic word_valid,
  input wire logic word_ready,
  input wire logic ram_addr_count_pulse,
  input wire logic overflow
);
  // --------
  // checks
  // --------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  AST_GNT_CAUSE: assert property ($rose(xfer_ram_grant) |-> $past(xfer_ram_request))
    else $error("grant without request");
  AST_GNT_DROP: assert property (xfer_ram_grant && !xfer_ram_request |=> !xfer_ram_grant)
    else $error("grant kept after request drop");
  AST_OVF_BLOCK: assert property (overflow && !xfer_ram_grant |=> !xfer_ram_grant)
    else $error("grant given after overflow");
  AST_GNT_HOLD: assert property (xfer_ram_grant && xfer_ram_request && !overflow |=> xfer_ram_grant || overflow)
    else $error("grant lost while requested");
  AST_PULSE_GNT: assert property (ram_addr_count_pulse |-> $past(xfer_ram_grant))
    else $error("count pulse without grant");
  AST_OVF_CAUSE: assert property ($rose(overflow) |-> ram_addr_count_pulse || $past(ram_addr_count_pulse))
    else $error("overflow without count");
  AST_STOP: assert property (!xfer_ram_grant && !$past(xfer_ram_grant) |-> !ram_addr_count_pulse)
    else $error("count pulse after stop");
  AST_STREAM_HOLD: assert property (word_valid && !word_ready && !overflow |=> word_valid && $stable(word_data))
    else $error("word dropped while stalled");
endmodule
`default_nettype wire

// File: verif/data_ram_address_and_grant_bench.sv
`timescale 1ns/1ps
`default_nettype none
module data_ram_address_and_grant_bench;
  logic clk, srst, start, wvalid, wready, wr, rd, creq, cgnt;
  logic [15:0] word, addr;
  logic [7:0] wdata, rdata;
  logic [3:0] psel;
  logic [11:0] raddr;
  int errors, checked, n;
  dram_if i_dram_if();
  dram_dev_end i_dram_dev_end(.I_CLK(clk), .I_SRST(srst), .I_CPU_ADDRESS_BUS(addr), .I_CPU_DATA(wdata),
    .I_CPU_WRITE_STROBE(wr), .I_CPU_READ_STROBE(rd), .I_CPU_RAM_REQUEST(creq), .O_CPU_RDATA(rdata),
    .O_CPU_RAM_GRANT(cgnt), .O_PAGE_SELECT(psel), .O_RAM_ADDR(raddr), .lnk(i_dram_if));
  dram_xfer_end i_dram_xfer_end(.I_CLK(clk), .I_SRST(srst), .I_START(start), .I_WORD(word),
    .I_WORD_VALID(wvalid), .O_WORD_READY(wready), .O_BUSY(), .lnk(i_dram_if));
  dram_sva i_dram_sva(.I_CLK(clk), .I_SRST(srst), .xfer_ram_request(i_dram_if.xfer_ram_request),
    .xfer_ram_grant(i_dram_if.xfer_ram_grant), .word_data(i_dram_if.word_data),
    .word_valid(i_dram_if.word_valid), .word_ready(i_dram_if.word_ready),
    .ram_addr_count_pulse(i_dram_if.ram_addr_count_pulse), .overflow(i_dram_if.overflow));
  // --------
  // tasks
  // --------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task cpu_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask
  task cpu_rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk) addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, e});
  endtask
  task cpu_grab;
    @(posedge clk) creq <= 1'b1;
    n = 0;
    while (cgnt !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) errors++;
  endtask
  task push(input logic [15:0] w);
    word <= w;
    wvalid <= 1'b1;
    n = 0;
    @(posedge clk);
    while (wready !== 1'b1 && i_dram_if.overflow !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) errors++;
  endtask
  // --------
  // run
  // --------
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    print_verdict;
  end
  initial begin
    srst = 1; start = 0; wvalid = 0; word = 0; addr = 0; wdata = 0; wr = 0; rd = 0; creq = 0;
    errors = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    cpu_rd(16'h6005, 8'h10);
    cpu_grab;
    chk(cgnt, 1);
    cpu_wr(16'h0C05, 8'h5A);
    cpu_rd(16'h0C05, 8'h5A);
    chk(psel, 4'b1000);
    chk(raddr, 12'hC05);
    cpu_wr(16'h6009, 8'hFE);
    cpu_wr(16'h600A, 8'h03);
    @(posedge clk) start <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(i_dram_if.xfer_ram_grant, 0);
    @(posedge clk) creq <= 1'b0;
    @(posedge clk) #1 chk(cgnt, 0);
    n = 0;
    while (i_dram_if.xfer_ram_grant !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk(i_dram_if.xfer_ram_grant, 1);
    for (int k = 0; k < 400 && i_dram_if.overflow !== 1'b1; k++) begin
      if (k == 20) begin
        wvalid <= 1'b0;
        creq <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(cgnt, 0);
        @(posedge clk) creq <= 1'b0;
      end
      push(16'h1234 + 16'(k));
    end
    wvalid <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(i_dram_if.overflow, 1);
    chk(i_dram_if.xfer_ram_grant, 0);
    cpu_grab;
    cpu_rd(16'h0CFE, 8'h34);
    cpu_rd(16'h0CFF, 8'h12);
    cpu_rd(16'h0D00, 8'h35);
    cpu_rd(16'h0FFF, 8'h13);
    @(posedge clk) creq <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(i_dram_if.xfer_ram_grant, 0);
    chk(psel, 4'b0000);
    @(posedge clk) start <= 1'b0;
    cpu_rd(16'h6005, 8'h11);
    cpu_wr(16'h6005, 8'h00);
    cpu_rd(16'h6005, 8'h00);
    print_verdict;
  end
endmodule
`default_nettype wire
